// ==== ebu_defines.svh ====
// constants of the external bus unit: modes, field positions, codes
// assumes inclusion by bare name from the window decoder and the bus unit files
`ifndef EBU_DEFINES_SVH
`define EBU_DEFINES_SVH

// ---------------------------------------------------------------
// widths
// ---------------------------------------------------------------
`define ADDR_W     24
`define DATA_W     16
`define CFG_W      16
`define WIN_N      4
`define CS_N       5
`define PORT_HI    15
`define BYTE_HI    7
`define SEG_HI     23
`define SEG_LO     16
`define PAGE_LO    12

// ---------------------------------------------------------------
// bus modes (bus config field)
// ---------------------------------------------------------------
`define MODE_SINGLE  3'h0
`define MODE_DEMUX16 3'h1
`define MODE_MUX16   3'h2
`define MODE_MUX8    3'h3
`define MODE_DEMUX8  3'h4

// ---------------------------------------------------------------
// address space limits
// ---------------------------------------------------------------
`define SPACE_16M  2'h0
`define SPACE_1M   2'h1
`define SPACE_256K 2'h2
`define SPACE_64K  2'h3
`define SEG_16M    8'hFF
`define SEG_1M     8'h0F
`define SEG_256K   8'h03
`define SEG_64K    8'h00

// ---------------------------------------------------------------
// bus config fields
// ---------------------------------------------------------------
`define BC_WAIT_HI   3
`define BC_WAIT_LO   0
`define BC_TRISTATE  4
`define BC_ALE_EXT   5
`define BC_RW_DELAY  6
`define BC_READY_EN  7
`define BC_READY_POL 8
`define BC_WIN_EN    9
`define BC_CS_EN     10
`define BC_MODE_HI   13
`define BC_MODE_LO   11

// ---------------------------------------------------------------
// range select fields
// ---------------------------------------------------------------
`define RS_BASE_HI 15
`define RS_BASE_LO 4
`define RS_SIZE_HI 3
`define RS_SIZE_LO 0
`define PAGE_MASK  12'hFFF
`define PAGE_ZERO  12'h000

// ---------------------------------------------------------------
// reset and idle values
// ---------------------------------------------------------------
`define CS_IDLE     5'h1F
`define WIN_DEFAULT 3'h0
`define WAIT_ZERO   4'h0
`define WAIT_ONE    4'h1
`define DATA_ZERO   16'h0000
`define BYTE_ZERO   8'h00
`define ADDR_ZERO   24'h000000
`define CFG_ZERO    16'h0000

`endif

// ==== ebu_pkg.sv ====
// types of the external bus unit
// assumes nothing beyond the compile order
package ebu_pkg;

  // ---------------------------------------------------------------
  // cycle sequencer states, one-hot
  // ---------------------------------------------------------------
  typedef enum logic [7:0] {
    ST_IDLE    = 8'h01,
    ST_ADDR    = 8'h02,
    ST_ALE_EXT = 8'h04,
    ST_DELAY   = 8'h08,
    ST_ACCESS  = 8'h10,
    ST_READY   = 8'h20,
    ST_RECOVER = 8'h40,
    ST_HELD    = 8'h80
  } state_t;

  typedef logic [15:0] cfg_t;

endpackage

// ==== window_decoder.sv ====
// address window decoder: hits, priority pick, config select
// assumes packed window fields, window 1 in the lowest slice
`timescale 1ns/10ps
`default_nettype none
`include "ebu_defines.svh"

module window_decoder (
  // window setup
  input  wire logic [`WIN_N*`CFG_W-1:0]      window_range_select,
  input  wire logic [`WIN_N*`CFG_W-1:0]      window_bus_config,
  input  wire logic [`CFG_W-1:0]             default_bus_config,
  // address under test
  input  wire logic [`ADDR_W-1:`PAGE_LO]     page,
  // decode result
  output logic      [`WIN_N-1:0]             window_hits,
  output logic      [2:0]                    window_index,
  output ebu_pkg::cfg_t                      sel_cfg
);

  ebu_pkg::cfg_t cfg_arr [0:`WIN_N];

  // ---------------------------------------------------------------
  // per-window match
  // ---------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < `WIN_N; i++) begin : g_win
      wire [11:0] base = window_range_select[i*`CFG_W+`RS_BASE_HI:i*`CFG_W+`RS_BASE_LO];
      wire [3:0]  size = window_range_select[i*`CFG_W+`RS_SIZE_HI:i*`CFG_W+`RS_SIZE_LO];
      wire [11:0] mask = `PAGE_MASK << size;
      assign cfg_arr[i+1] = window_bus_config[i*`CFG_W +: `CFG_W];
      assign window_hits[i] = cfg_arr[i+1][`BC_WIN_EN] && (((page ^ base) & mask) == `PAGE_ZERO);
    end
  endgenerate

  assign cfg_arr[0] = default_bus_config;

  // ---------------------------------------------------------------
  // priority: later window wins, so 4 over 3 and 2 over 1
  // ---------------------------------------------------------------
  always_comb begin
    window_index = `WIN_DEFAULT;
    for (int j = 0; j < `WIN_N; j++) begin
      if (window_hits[j]) begin
        window_index = 3'(j + 1); // [R6] [R7]
      end
    end
  end

  assign sel_cfg = cfg_arr[window_index]; // [R5]

endmodule
`default_nettype wire

// ==== external_bus_unit.sv ====
// external bus unit: cycle sequencer, pin drive, chip selects, arbitration
// assumes cpu request held until access_done; pins resolved outside
// Function
// R1: single-chip refusal plus four external modes, 8/16-bit, muxed or not, 16-24 address bits
// R2: demuxed modes put address on address port, data on data port, low byte for 8-bit
// R3: muxed modes share one port, address first, then data
// R4: cycle time, tri-state time, latch strobe length and strobe delay are programmable
// R5: four windows, each a range select paired with its own bus config
// R6: window four beats three, window two beats one on overlap
// R7: addresses outside every window use the default bus config
// R8: five active-low chip selects, four windows plus default
// R9: arbitration pins handled only once arbitration enable is set
// R10: after reset act as arbitration master, grant pin driven
// R11: grant pin direction set makes us slave, grant pin becomes input
// R12: address space limited to 1M, 256K or 64K trims segment lines
// R13: by default chip selects change half a clock after latch strobe rises
// R14: timing select set makes chip selects change with the latch strobe rise
// R15: per-window polarity bit picks ready active level
// R16: device ends ready-enabled cycles by driving ready active; we wait
// R17: on request finish cycle, float bus, grant; regain request asks back
// R18: chip select asserted only for external accesses decoded to its region
`timescale 1ns/10ps
`default_nettype none
`include "ebu_defines.svh"

module external_bus_unit (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        nrst,
  // cpu access request
  input  wire logic                        access_req,
  input  wire logic                        access_write,
  input  wire logic [`ADDR_W-1:0]          access_addr,
  input  wire logic [`DATA_W-1:0]          access_wdata,
  output logic                             access_done,
  output logic                             access_error,
  output logic      [`DATA_W-1:0]          access_rdata,
  // configuration
  input  wire logic                        chip_select_timing_select,
  input  wire logic [1:0]                  addr_space,
  input  wire logic                        arbitration_enable,
  input  wire logic                        grant_pin_direction,
  input  wire logic [`WIN_N*`CFG_W-1:0]    window_range_select,
  input  wire logic [`WIN_N*`CFG_W-1:0]    window_bus_config,
  input  wire logic [`CFG_W-1:0]           default_bus_config,
  // bus pins
  output logic      [`DATA_W-1:0]          shared_data_drive,
  input  wire logic [`DATA_W-1:0]          shared_data_sense,
  output logic                             shared_data_oe_n,
  output logic      [`DATA_W-1:0]          address_port,
  output logic      [7:0]                  segment_port,
  output logic                             bus_ctrl_oe_n,
  output logic                             ale,
  output logic                             read_n,
  output logic                             write_n,
  output logic      [`CS_N-1:0]            chip_select_outputs_n,
  input  wire logic                        ready_in,
  // arbitration pins
  input  wire logic                        hold_request_n,
  output logic                             bus_release_grant_n_drive,
  input  wire logic                        bus_release_grant_n_sense,
  output logic                             bus_release_grant_oe_n,
  output logic                             bus_regain_request_n,
  // status
  output logic                             bus_owned
);

  // ---------------------------------------------------------------
  // state and latched cycle context
  // ---------------------------------------------------------------
  ebu_pkg::state_t state;
  ebu_pkg::state_t next_state;
  ebu_pkg::cfg_t   cfg_q;
  logic [2:0]          win_q;
  logic [`ADDR_W-1:0]  addr_q;
  logic [`DATA_W-1:0]  wdata_q;
  logic                write_q;
  logic [3:0]          wait_cnt;
  logic [`CS_N-1:0]    cs_pos;
  logic [`CS_N-1:0]    cs_neg;

  wire [`WIN_N-1:0] win_hits;
  wire [2:0]        sel_index;
  ebu_pkg::cfg_t    sel_cfg;

  window_decoder u_dec (
    .window_range_select (window_range_select),
    .window_bus_config   (window_bus_config),
    .default_bus_config  (default_bus_config),
    .page                (access_addr[`ADDR_W-1:`PAGE_LO]),
    .window_hits         (win_hits),
    .window_index        (sel_index),
    .sel_cfg             (sel_cfg)
  );

  // ---------------------------------------------------------------
  // arbitration decode
  // ---------------------------------------------------------------
  wire arb_master = arbitration_enable && !grant_pin_direction; // [R9] [R10]
  wire arb_slave  = arbitration_enable && grant_pin_direction;  // [R11]
  // slave owns the bus only while the other master grants it
  wire hold_now   = (arb_master && !hold_request_n) ||
                    (arb_slave && bus_release_grant_n_sense); // [R17]
  wire hold_exit  = !arbitration_enable ||
                    (arb_master ? hold_request_n : !bus_release_grant_n_sense);

  // ---------------------------------------------------------------
  // start decode and current context
  // ---------------------------------------------------------------
  // access_done gate stops a held request from starting twice
  wire start = (state == ebu_pkg::ST_IDLE) && access_req && !access_done && !hold_now;
  wire [`CFG_W-1:0]  cur_cfg   = start ? sel_cfg : cfg_q;
  wire [2:0]         cur_win   = start ? sel_index : win_q;
  wire [`ADDR_W-1:0] cur_addr  = start ? access_addr : addr_q;
  wire [`DATA_W-1:0] cur_wdata = start ? access_wdata : wdata_q;
  wire               cur_write = start ? access_write : write_q;
  wire [2:0]         cur_mode  = cur_cfg[`BC_MODE_HI:`BC_MODE_LO];

  wire is_mux  = (cur_mode == `MODE_MUX16) || (cur_mode == `MODE_MUX8);
  wire is_8bit = (cur_mode == `MODE_MUX8) || (cur_mode == `MODE_DEMUX8);
  wire is_ext  = is_mux || (cur_mode == `MODE_DEMUX16) || (cur_mode == `MODE_DEMUX8);
  wire refuse  = start && !is_ext; // [R1]

  wire ready_active = (ready_in == cfg_q[`BC_READY_POL]); // [R15]
  wire wait_done    = (wait_cnt == `WAIT_ZERO);
  wire finish = ((state == ebu_pkg::ST_ACCESS) && wait_done &&
                 (!cfg_q[`BC_READY_EN] || ready_active)) ||
                ((state == ebu_pkg::ST_READY) && ready_active); // [R16]
  wire after_read = cfg_q[`BC_TRISTATE] && !write_q; // [R4]

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      ebu_pkg::ST_IDLE: begin
        if (hold_now) begin
          next_state = ebu_pkg::ST_HELD; // [R17]
        end else if (start && !refuse) begin
          next_state = ebu_pkg::ST_ADDR;
        end
      end
      ebu_pkg::ST_ADDR: begin
        if (cfg_q[`BC_ALE_EXT]) begin
          next_state = ebu_pkg::ST_ALE_EXT; // [R4]
        end else if (cfg_q[`BC_RW_DELAY]) begin
          next_state = ebu_pkg::ST_DELAY;
        end else begin
          next_state = ebu_pkg::ST_ACCESS;
        end
      end
      ebu_pkg::ST_ALE_EXT: begin
        next_state = cfg_q[`BC_RW_DELAY] ? ebu_pkg::ST_DELAY : ebu_pkg::ST_ACCESS;
      end
      ebu_pkg::ST_DELAY: begin
        next_state = ebu_pkg::ST_ACCESS;
      end
      ebu_pkg::ST_ACCESS: begin
        if (finish) begin
          next_state = after_read ? ebu_pkg::ST_RECOVER : ebu_pkg::ST_IDLE;
        end else if (wait_done) begin
          next_state = ebu_pkg::ST_READY;
        end
      end
      ebu_pkg::ST_READY: begin
        if (finish) begin
          next_state = after_read ? ebu_pkg::ST_RECOVER : ebu_pkg::ST_IDLE;
        end
      end
      ebu_pkg::ST_RECOVER: begin
        next_state = ebu_pkg::ST_IDLE;
      end
      ebu_pkg::ST_HELD: begin
        if (hold_exit) begin
          next_state = ebu_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = ebu_pkg::ST_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // next pin values
  // ---------------------------------------------------------------
  wire in_addr  = (next_state == ebu_pkg::ST_ADDR) || (next_state == ebu_pkg::ST_ALE_EXT);
  wire in_strb  = (next_state == ebu_pkg::ST_ACCESS) || (next_state == ebu_pkg::ST_READY);
  wire in_data  = in_strb || (next_state == ebu_pkg::ST_DELAY);
  wire in_cycle = in_addr || in_data;
  wire [3:0] next_wait = start ? cur_cfg[`BC_WAIT_HI:`BC_WAIT_LO] :
                         ((state == ebu_pkg::ST_ACCESS) && !wait_done) ?
                         4'(wait_cnt - `WAIT_ONE) : wait_cnt; // [R4]
  wire next_read_n  = !(in_strb && !cur_write);
  wire next_write_n = !(in_strb && cur_write);
  // muxed: port carries address while the strobe is high, then data
  wire next_data_oe_n = !((is_mux && in_addr) || (cur_write && in_data)); // [R3]
  wire [`DATA_W-1:0] wdata_lane = is_8bit ? {`BYTE_ZERO, cur_wdata[`BYTE_HI:0]} : cur_wdata;
  wire [`DATA_W-1:0] next_data = (is_mux && in_addr) ? cur_addr[`PORT_HI:0] : wdata_lane; // [R2] [R3]
  wire [`DATA_W-1:0] next_aport = (!is_mux && in_cycle) ? cur_addr[`PORT_HI:0] : `DATA_ZERO; // [R2]
  wire [7:0] seg_mask = (addr_space == `SPACE_1M)   ? `SEG_1M :
                        (addr_space == `SPACE_256K) ? `SEG_256K :
                        (addr_space == `SPACE_64K)  ? `SEG_64K : `SEG_16M; // [R12]
  wire [7:0] next_seg = in_cycle ? (cur_addr[`SEG_HI:`SEG_LO] & seg_mask) : `BYTE_ZERO;
  wire [`DATA_W-1:0] read_lane = is_8bit ? {`BYTE_ZERO, shared_data_sense[`BYTE_HI:0]}
                                         : shared_data_sense;

  wire [`CS_N-1:0] cs_hit;
  genvar k;
  generate
    for (k = 0; k < `CS_N; k++) begin : g_cs
      assign cs_hit[k] = (cur_win == 3'(k)); // [R8]
    end
  endgenerate
  wire [`CS_N-1:0] next_cs = (in_cycle && cur_cfg[`BC_CS_EN]) ? ~cs_hit : `CS_IDLE; // [R18]

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state   <= ebu_pkg::ST_IDLE;
      cfg_q   <= `CFG_ZERO;
      win_q   <= `WIN_DEFAULT;
      addr_q  <= `ADDR_ZERO;
      wdata_q <= `DATA_ZERO;
      write_q <= 1'b0;
    end else begin
      state <= next_state;
      if (start) begin
        cfg_q   <= sel_cfg;
        win_q   <= sel_index;
        addr_q  <= access_addr;
        wdata_q <= access_wdata;
        write_q <= access_write;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wait_cnt          <= `WAIT_ZERO;
      ale               <= 1'b0;
      read_n            <= 1'b1;
      write_n           <= 1'b1;
      shared_data_oe_n  <= 1'b1;
      shared_data_drive <= `DATA_ZERO;
      address_port      <= `DATA_ZERO;
      segment_port      <= `BYTE_ZERO;
      bus_ctrl_oe_n     <= 1'b0;
      cs_pos            <= `CS_IDLE;
    end else begin
      wait_cnt          <= next_wait;
      ale               <= in_addr;
      read_n            <= next_read_n;
      write_n           <= next_write_n;
      shared_data_oe_n  <= next_data_oe_n;
      shared_data_drive <= next_data;
      address_port      <= next_aport;
      segment_port      <= next_seg;
      bus_ctrl_oe_n     <= (next_state == ebu_pkg::ST_HELD); // [R17]
      cs_pos            <= next_cs; // [R14]
    end
  end

  // half-cycle copy; only one clock, so the falling edge gives the half step
  always_ff @(negedge clk or negedge nrst) begin
    if (!nrst) begin
      cs_neg <= `CS_IDLE;
    end else begin
      cs_neg <= cs_pos; // [R13]
    end
  end

  assign chip_select_outputs_n = chip_select_timing_select ? cs_pos : cs_neg; // [R13] [R14]

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      access_done               <= 1'b0;
      access_error              <= 1'b0;
      access_rdata              <= `DATA_ZERO;
      bus_release_grant_n_drive <= 1'b1;
      bus_release_grant_oe_n    <= 1'b1;
      bus_regain_request_n      <= 1'b1;
      bus_owned                 <= 1'b1;
    end else begin
      access_done  <= finish || refuse;
      access_error <= refuse; // [R1]
      if (finish && !write_q) begin
        access_rdata <= read_lane;
      end
      bus_release_grant_n_drive <= !(arb_master && (next_state == ebu_pkg::ST_HELD)); // [R17]
      bus_release_grant_oe_n    <= !arb_master; // [R10] [R11]
      bus_regain_request_n      <= !(arbitration_enable && access_req &&
                                     (next_state == ebu_pkg::ST_HELD)); // [R17]
      bus_owned <= (next_state != ebu_pkg::ST_HELD);
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_ready_pending;
    (state == ebu_pkg::ST_READY) && !ready_active;
  endsequence
  sequence s_refused_start;
    start && refuse;
  endsequence

  a_refuse_single: assert property (s_refused_start |=> access_done && access_error && !ale) // [R1]
    else $error("single-chip access not refused");
  a_demux_address: assert property ((state == ebu_pkg::ST_ACCESS) && !is_mux |->
    address_port == addr_q[`PORT_HI:0]) // [R2]
    else $error("demux address missing");
  a_mux_addr_phase: assert property (ale && is_mux |-> !shared_data_oe_n &&
    shared_data_drive == addr_q[`PORT_HI:0]) // [R3]
    else $error("mux address phase wrong");
  a_wait_states: assert property ((state == ebu_pkg::ST_ACCESS) && !wait_done |=>
    (state == ebu_pkg::ST_ACCESS) && !read_n != !write_n) // [R4]
    else $error("wait state skipped");
  a_window_priority: assert property (win_hits[3] |-> sel_index == 3'h4) // [R6]
    else $error("window four lost priority");
  a_default_window: assert property (win_hits == 4'h0 |-> sel_index == `WIN_DEFAULT) // [R7]
    else $error("default region not chosen");
  a_cs_single: assert property ($onehot0(~cs_pos)) // [R8]
    else $error("more than one chip select");
  a_arb_off: assert property (!arbitration_enable |=> state != ebu_pkg::ST_HELD) // [R9]
    else $error("held without arbitration");
  a_grant_dir: assert property (!bus_release_grant_oe_n |-> // [R10] [R11]
    !$past(grant_pin_direction) && $past(arbitration_enable))
    else $error("grant driven as slave");
  a_seg_space: assert property (addr_space == `SPACE_64K |=> segment_port == `BYTE_ZERO) // [R12]
    else $error("segment lines not trimmed");
  a_cs_with_ale: assert property ($rose(ale) && cfg_q[`BC_CS_EN] |-> cs_pos != `CS_IDLE) // [R14]
    else $error("chip select late");
  a_ready_wait: assert property (s_ready_pending |=> !access_done ##0
    state == ebu_pkg::ST_READY) // [R16]
    else $error("cycle ended without ready");
  a_held_float: assert property ((state == ebu_pkg::ST_HELD) |-> bus_ctrl_oe_n &&
    shared_data_oe_n) // [R17]
    else $error("bus driven while held");
  a_cs_only_cycle: assert property (cs_pos != `CS_IDLE |-> !(state inside
    {ebu_pkg::ST_IDLE, ebu_pkg::ST_HELD, ebu_pkg::ST_RECOVER})) // [R18]
    else $error("chip select outside access");

endmodule
`default_nettype wire

// ==== ext_device.sv ====
// far-side device model: one data word, strobe-timed ready
// assumes strobes from the bus unit, ready polarity set by bench
`timescale 1ns/10ps
`default_nettype none

module ext_device (
  // bus side
  input  wire logic        clk,
  input  wire logic        read_n,
  input  wire logic        write_n,
  input  wire logic [15:0] shared_data_drive,
  output logic      [15:0] shared_data_sense,
  output logic             ready_in,
  // bench control
  input  wire logic        ready_pol,
  input  wire logic        slow
);
  logic [15:0] mem;
  logic [15:0] last;
  logic [2:0]  cnt;
  logic        idle;

  assign idle = read_n & write_n;
  always_ff @(posedge clk) begin
    if (!write_n) begin
      mem <= shared_data_drive;
    end
    if (!read_n) begin
      last <= mem;
    end
    cnt <= idle ? 3'h0 : cnt + {2'h0, cnt != 3'h7};
  end
  // released bus shows no stale value
  assign shared_data_sense = read_n ? ~last : mem;
  // slow device holds off three strobe cycles before ending the cycle
  assign ready_in = (idle || (slow && cnt < 3'h3)) ? ~ready_pol : ready_pol;
endmodule
`default_nettype wire

// ==== test_external_bus_unit.sv ====
// scenario bench of the external bus unit
// assumes ext_device compiled first; grant pin resolved here
`timescale 1ns/10ps
`default_nettype none

module test_external_bus_unit;
  // -------------------------------------------------------------
  // signals
  // -------------------------------------------------------------
  logic clk, nrst, access_req, access_write, access_done, access_error, er;
  logic chip_select_timing_select, arbitration_enable, grant_pin_direction;
  logic ale, read_n, write_n, ready_in, hold_request_n, bus_ctrl_oe_n, bus_owned;
  logic bus_release_grant_n_drive, bus_release_grant_n_sense, bus_release_grant_oe_n;
  logic bus_regain_request_n, shared_data_oe_n, ready_pol, slow, tb_grant;
  logic [1:0]  addr_space;
  logic [23:0] access_addr;
  logic [15:0] access_wdata, access_rdata, shared_data_drive, shared_data_sense;
  logic [15:0] address_port, default_bus_config, rd, ap;
  logic [63:0] window_range_select, window_bus_config;
  logic [7:0]  segment_port, sp;
  logic [4:0]  chip_select_outputs_n, cs_r, cs_m;
  int          n_errors, checked, cyc;

  assign bus_release_grant_n_sense = bus_release_grant_oe_n ? tb_grant : bus_release_grant_n_drive;
  external_bus_unit u_external_bus_unit (.*);
  ext_device u_ext_device (.*);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic complete_run();
    if (n_errors == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp) begin
      $display("unexpected %0t got %0h want %0h", $time, got, exp);
      n_errors++;
    end
  endtask

  // mode, ready enable, ready polarity; window and chip select enabled
  function automatic logic [15:0] bc(input logic [2:0] m, input logic re, input logic rp);
    return {2'h0, m, 1'b1, 1'b1, rp, re, 7'h00};
  endfunction

  // cs sampled just after the latch strobe rise and half a clock later
  task automatic acc(input logic wr, input logic [23:0] a, input logic [15:0] wd);
    bit seen;
    seen = 0;
    access_write = wr;
    access_addr = a;
    access_wdata = wd;
    access_req = 1'b1;
    for (cyc = 0; cyc < 60 && access_done !== 1'b1; cyc++) begin
      @(posedge clk);
      #1;
      if (ale === 1'b1 && !seen) begin
        seen = 1;
        cs_r = chip_select_outputs_n;
        ap = address_port;
        sp = segment_port;
        #5;
        cs_m = chip_select_outputs_n;
      end
    end
    if (cyc == 60) begin
      n_errors++;
      complete_run();
    end
    er = access_error;
    rd = access_rdata;
    @(negedge clk);
    access_req = 1'b0;
    @(negedge clk);
  endtask

  task automatic s_default();
    logic [7:0] mk [4];
    mk = '{8'hFF, 8'h0F, 8'h03, 8'h00};
    acc(1'b1, 24'h123456, 16'hA5C3);
    chk(cs_r, 5'h1F);
    chk(cs_m, 5'h1E);
    chk(ap, 16'h3456);
    acc(1'b0, 24'h123456, 16'h0000);
    chk(rd, 16'hA5C3);
    chip_select_timing_select = 1'b1;
    for (int i = 0; i < 4; i++) begin
      addr_space = 2'(i);
      acc(1'b0, 24'hFF0000, 16'h0000);
      chk(sp, mk[i]);
      chk(cs_r, 5'h1E);
    end
    default_bus_config = bc(3'h3, 1'b0, 1'b0);
    acc(1'b1, 24'h000010, 16'hBEEF);
    acc(1'b0, 24'h000010, 16'h0000);
    chk(rd, 16'h00EF);
    chk(ap, 16'h0000);
    default_bus_config = bc(3'h0, 1'b0, 1'b0);
    acc(1'b0, 24'h000010, 16'h0000);
    chk(er, 1'b1);
    default_bus_config = bc(3'h1, 1'b0, 1'b0);
  endtask

  // demux8 with wait 3, latch extend, strobe delay and recover cycle
  task automatic s_timing();
    default_bus_config = bc(3'h4, 1'b0, 1'b0) | 16'h0073;
    acc(1'b1, 24'h000020, 16'h1234);
    chk(ap, 16'h0020);
    chk(24'(cyc), 24'h000008);
    acc(1'b0, 24'h000020, 16'h0000);
    chk(rd, 16'h0034);
    chk(24'(cyc), 24'h000008);
    default_bus_config = bc(3'h1, 1'b0, 1'b0);
  endtask

  task automatic s_prio();
    window_range_select = {16'h2000, 16'h2000, 16'h1000, 16'h1000};
    window_bus_config = {bc(3'h1, 1'b0, 1'b0), bc(3'h1, 1'b0, 1'b0), bc(3'h2, 1'b0, 1'b0), bc(3'h1, 1'b0, 1'b0)};
    acc(1'b1, 24'h100020, 16'h5A96);
    chk(cs_m, 5'h1B);
    chk(ap, 16'h0000);
    acc(1'b0, 24'h100020, 16'h0000);
    chk(rd, 16'h5A96);
    acc(1'b0, 24'h200020, 16'h0000);
    chk(cs_m, 5'h0F);
  endtask

  task automatic s_ready();
    window_range_select[15:0] = 16'h3000;
    slow = 1'b1;
    for (int p = 0; p < 2; p++) begin
      ready_pol = 1'(p);
      window_bus_config[15:0] = bc(3'h1, 1'b1, 1'(p));
      acc(1'b0, 24'h300000, 16'h0000);
      chk(24'(cyc > 4), 24'h1);
      chk(cs_m, 5'h1D);
    end
    slow = 1'b0;
  endtask

  task automatic s_arb();
    hold_request_n = 1'b0;
    acc(1'b0, 24'h123456, 16'h0000);
    chk(bus_owned, 1'b1);
    chk(bus_release_grant_oe_n, 1'b1);
    arbitration_enable = 1'b1;
    repeat (2) @(negedge clk);
    chk(bus_release_grant_oe_n, 1'b0);
    access_write = 1'b0;
    access_addr = 24'h123456;
    hold_request_n = 1'b0;
    access_req = 1'b1;
    repeat (2) @(negedge clk);
    chk(bus_release_grant_n_drive, 1'b0);
    chk(bus_ctrl_oe_n, 1'b1);
    chk(shared_data_oe_n, 1'b1);
    chk(bus_owned, 1'b0);
    chk(bus_regain_request_n, 1'b0);
    hold_request_n = 1'b1;
    acc(1'b0, 24'h123456, 16'h0000);
    chk(bus_release_grant_n_drive, 1'b1);
    tb_grant = 1'b0;
    grant_pin_direction = 1'b1;
    repeat (2) @(negedge clk);
    chk(bus_release_grant_oe_n, 1'b1);
    acc(1'b0, 24'h123456, 16'h0000);
    chk(rd, 16'h5A96);
  endtask

  initial begin
    {nrst, access_req, access_write, chip_select_timing_select, arbitration_enable} = 5'h00;
    {grant_pin_direction, slow, addr_space, access_addr, access_wdata} = 44'h0;
    {window_range_select, window_bus_config} = 128'h0;
    default_bus_config = bc(3'h1, 1'b0, 1'b0);
    {hold_request_n, ready_pol, tb_grant} = 3'h7;
    n_errors = 0;
    checked = 0;
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    s_default();
    s_timing();
    s_prio();
    s_ready();
    s_arb();
    complete_run();
  end
endmodule
`default_nettype wire
